// >>> cbu_pkg.sv
// cbu_pkg: constants and carrier types for the conditional branch unit
// assumes a 16-bit instruction word and a 21-bit byte program counter
package cbu_pkg;
	// ****************************************
	// widths and encodings
	// ****************************************
	localparam int CBU_PC_W = 21;
	localparam logic [3:0] CBU_OP_BRANCH = 4'he;
	localparam logic [3:0] CBU_SUB_NO_OVF = 4'h5;
	localparam logic [3:0] CBU_SUB_NONZERO = 4'h1;
	localparam logic [CBU_PC_W-1:0] CBU_PC_RESET = 21'h000000;
	localparam logic [CBU_PC_W-1:0] CBU_WORD_STEP = 21'h000002;
	localparam logic [1:0] CBU_Q_RESET = 2'h0;
	localparam logic [1:0] CBU_Q_LAST = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [15:0] word;
		logic valid;
	} cbu_instr_t;

	typedef struct packed {
		logic overflow_flag;
		logic zero_flag;
	} cbu_flags_t;

	typedef enum logic [1:0] {
		CBU_EXEC = 2'b01,
		CBU_FLUSH = 2'b10
	} cbu_state_t;
endpackage

// >>> cbu_branch_unit.sv
// cbu_branch_unit: decodes and executes the two conditional branches
// assumes the fetch stage presents the word during phase 0 of a cycle
// Function
// [RL1] branch on no-overflow only if flag is 0
// [RL2] branch on nonzero only if zero flag 0
// [RL3] offset is signed byte, doubled, added
// [RL4] target equals instruction address plus 2 plus 2n
// [RL5] one word; one cycle, two if taken
// [RL6] phase 4 writes counter; taken adds idle cycle
// [RL7] decode 1110 with 0101 or 0001; flags untouched
`timescale 1ns/1ps
module cbu_branch_unit
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire cbu_pkg::cbu_instr_t instr_in,
	input wire cbu_pkg::cbu_flags_t flags_in,
	output logic [cbu_pkg::CBU_PC_W-1:0] program_counter_out,
	output logic [1:0] phase_out,
	output logic taken_out,
	output logic flush_out,
	output logic is_branch_out
);
	import cbu_pkg::*;

	// ****************************************
	// timing overview
	// ****************************************
	// one instruction cycle is four enabled clock edges, counted in q
	// from 0 to 3; the word and the flags must stand for all four of
	// them, because the decision is taken combinationally and only
	// used at the edge that ends phase 3
	// a branch that is not taken leaves the counter one word ahead
	// a taken branch writes the target at that same edge and then
	// spends a whole cycle in flush, where any word offered is ignored
	// clk_en_in low freezes the phase counter, the state and the
	// counter together, so a stalled cycle resumes where it stopped

	// ****************************************
	// decode
	// ****************************************
	function automatic logic dec_sub(input logic [15:0] w,
		input logic [3:0] sub);
		dec_sub = (w[15:12] == CBU_OP_BRANCH) && (w[11:8] == sub);
	endfunction

	cbu_state_t state;
	cbu_state_t next_state;
	logic [1:0] q;
	logic [CBU_PC_W-1:0] pc;
	logic taken_latch;
	wire is_no_ovf = instr_in.valid && dec_sub(instr_in.word, CBU_SUB_NO_OVF); // RL7
	wire is_nonzero = instr_in.valid && dec_sub(instr_in.word, CBU_SUB_NONZERO); // RL7
	wire cond_true = (is_no_ovf && !flags_in.overflow_flag) // RL1
		|| (is_nonzero && !flags_in.zero_flag); // RL2
	wire [CBU_PC_W-1:0] offset2 = CBU_PC_W'({{(CBU_PC_W-9){instr_in.word[7]}},
		instr_in.word[7:0], 1'b0}); // RL3
	wire [CBU_PC_W-1:0] pc_inc = pc + CBU_WORD_STEP;
	wire [CBU_PC_W-1:0] target = pc_inc + offset2; // RL4
	wire in_exec = (state == CBU_EXEC);
	wire last_q = (q == CBU_Q_LAST);
	wire take_now = in_exec && cond_true;

	// next state: a taken branch adds one all-idle cycle
	// the move into flush happens only at the last phase, so the
	// three earlier phases of a taken cycle still count as execute
	// flush always lasts exactly four enabled edges and then returns
	// the default branch brings an illegal code back to execute
	always_comb
	begin
		next_state = state;
		case (state)
			CBU_EXEC: if (last_q && take_now) next_state = CBU_FLUSH; // RL5
			CBU_FLUSH: if (last_q) next_state = CBU_EXEC; // RL6
			default: next_state = CBU_EXEC;
		endcase
	end

	// phase counter and state
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			q <= CBU_Q_RESET;
			state <= CBU_EXEC;
		end
		else if (clk_en_in)
		begin
			q <= q + 2'h1;
			state <= next_state;
		end
	end

	// program counter written in phase 4 only; flags are never written
	// in execute the counter is always written: either one word ahead or to
	// the branch target, which itself is built on the advanced value
	// in flush the counter holds, and the taken marker is dropped at
	// the end of the flush so that it stands for that cycle only
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pc <= CBU_PC_RESET;
			taken_latch <= 1'b0;
		end
		else if (clk_en_in && last_q && in_exec)
		begin
			pc <= take_now ? target : pc_inc; // RL6
			taken_latch <= take_now;
		end
		else if (clk_en_in && last_q)
			taken_latch <= 1'b0;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign program_counter_out = pc;
	assign phase_out = q;
	assign taken_out = taken_latch;
	assign flush_out = (state == CBU_FLUSH);
	assign is_branch_out = in_exec && (is_no_ovf || is_nonzero);

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	AST_TAKEN_TARGET: assert property (clk_en_in && last_q && take_now // RL4
		|=> pc == $past(target)) else $error("taken target wrong");
	AST_NOT_TAKEN_STEP: assert property (clk_en_in && last_q && in_exec // RL5
		&& !take_now |=> pc == $past(pc) + CBU_WORD_STEP)
		else $error("sequential step wrong");
	AST_OVF_BLOCKS: assert property (is_no_ovf && flags_in.overflow_flag // RL1
		&& !is_nonzero |-> !take_now) else $error("overflow branch taken");
	AST_ZERO_BLOCKS: assert property (is_nonzero && flags_in.zero_flag // RL2
		|-> !take_now) else $error("zero branch taken");
	AST_FLUSH_AFTER: assert property (clk_en_in && last_q && take_now // RL6
		|=> flush_out) else $error("no idle cycle after taken");
	AST_PC_HOLD: assert property (!(clk_en_in && last_q) // RL6
		|=> $stable(pc)) else $error("pc changed outside phase 4");
	AST_FLUSH_NO_WRITE: assert property (flush_out && clk_en_in // RL5
		|=> $stable(pc)) else $error("pc written in idle cycle");
	AST_OFFSET_SIGN: assert property (offset2[0] == 1'b0 // RL3
		&& offset2[CBU_PC_W-1] == instr_in.word[7])
		else $error("offset not doubled signed");
	AST_DECODE: assert property (is_branch_out // RL7
		|-> instr_in.word[15:12] == 4'he) else $error("bad decode");

	COV_TAKEN_OVF: cover property (last_q && take_now && is_no_ovf);
	COV_TAKEN_NZ: cover property (last_q && take_now && is_nonzero);
	COV_NOT_TAKEN: cover property (last_q && is_branch_out && !take_now);
	COV_BACKWARD: cover property (last_q && take_now && instr_in.word[7]);
	COV_FREEZE: cover property (!clk_en_in && flush_out);

	// ****************************************
	// clock enable and phase sequencing
	// ****************************************
	// a low enable must hold the phase counter
	AST_FREEZE_PHASE: assert property (!clk_en_in |=> $stable(q)) // RL6
		else $error("phase moved while frozen");

	// a low enable must hold the execute or flush state
	AST_FREEZE_STATE: assert property (!clk_en_in |=> $stable(state)) // RL5
		else $error("state moved while frozen");

	// a low enable must hold the program counter
	AST_FREEZE_PC: assert property (!clk_en_in |=> $stable(pc)) // RL6
		else $error("pc moved while frozen");

	// each enabled edge advances the phase by one, wrapping after 3
	AST_PHASE_STEP: assert property (clk_en_in // RL6
		|=> q == $past(q) + 2'h1) else $error("phase skipped");

	// the state register never leaves its one-hot codes
	AST_STATE_ONEHOT: assert property ($onehot(state)) // RL5
		else $error("state not one-hot");

	// ****************************************
	// decode and cycle count
	// ****************************************
	// a recognised branch carries one of the two sub-opcodes
	AST_DECODE_SUB: assert property (is_branch_out // RL7
		|-> (instr_in.word[11:8] == CBU_SUB_NO_OVF)
		|| (instr_in.word[11:8] == CBU_SUB_NONZERO))
		else $error("bad sub decode");

	// words offered during the idle cycle are never decoded
	AST_FLUSH_IGNORES: assert property (flush_out // RL6
		|-> !is_branch_out) else $error("word decoded in flush");

	// a taken branch raises the taken marker for the idle cycle
	AST_TAKEN_FLAG: assert property (clk_en_in && last_q && take_now // RL5
		|=> taken_out) else $error("taken marker missing");

	// a branch not taken costs one cycle: no idle cycle follows
	AST_NO_FLUSH: assert property (clk_en_in && last_q && in_exec // RL5
		&& !take_now |=> !flush_out) else $error("idle after not taken");

	// the idle cycle ends after its own last phase
	AST_FLUSH_ENDS: assert property (clk_en_in && last_q && flush_out // RL5
		|=> !flush_out && !taken_out) else $error("idle cycle too long");
endmodule

// >>> cbu_tb.sv
// tb: self-checking bench for the conditional branch unit
// assumes words are taken at the edge that ends phase 3
`timescale 1ns/1ps
module tb;
	import cbu_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic clk_en = 1'b1;
	cbu_instr_t instr_in = '0;
	cbu_flags_t flags_in = '0;
	logic [CBU_PC_W-1:0] program_counter_out;
	logic [CBU_PC_W-1:0] exp_pc = '0;
	logic [1:0] phase_out;
	logic taken_out, flush_out, is_branch_out;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	cbu_branch_unit dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.clk_en_in(clk_en), .instr_in(instr_in), .flags_in(flags_in),
		.program_counter_out(program_counter_out), .phase_out(phase_out),
		.taken_out(taken_out), .flush_out(flush_out),
		.is_branch_out(is_branch_out));
	// free-running clock, 100 ns period
	initial forever #50 clk_sys_in = ~clk_sys_in;
	// cycle ceiling against a hang
	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 1000) stop_test(1'b1);
	end
	task automatic cmp_pc(input logic [CBU_PC_W-1:0] e, s);
		samples_checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("unexpected pc expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_phase(input logic [1:0] e, s);
		samples_checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("unexpected phase expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_bit(input string n, input logic e, s);
		samples_checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("unexpected %s expected %b seen %b", n, e, s);
		end
	endtask
	// one instruction cycle, plus the idle cycle when taken
	task automatic step(input logic [15:0] w, input cbu_flags_t f);
		logic dec, go;
		dec = w[15:12] == CBU_OP_BRANCH &&
			(w[11:8] == CBU_SUB_NO_OVF || w[11:8] == CBU_SUB_NONZERO);
		go = dec && (w[11:8] == CBU_SUB_NO_OVF ? !f.overflow_flag
			: !f.zero_flag);
		instr_in <= '{word: w, valid: 1'b1};
		flags_in <= f;
		@(negedge clk_sys_in);
		cmp_pc(exp_pc, program_counter_out);
		cmp_bit("decode", dec, is_branch_out);
		cmp_bit("flush", 1'b0, flush_out);
		cmp_bit("taken", 1'b0, taken_out);
		cmp_phase(2'h0, phase_out);
		exp_pc = exp_pc + CBU_WORD_STEP;
		if (go) exp_pc = exp_pc + {{12{w[7]}}, w[7:0], 1'b0};
		repeat (4) @(posedge clk_sys_in);
		if (go)
		begin
			// a word offered in the idle cycle must be ignored
			instr_in <= '{word: 16'he5ff, valid: 1'b1};
			flags_in <= '0;
			@(negedge clk_sys_in);
			cmp_bit("flush", 1'b1, flush_out);
			cmp_bit("taken", 1'b1, taken_out);
			cmp_pc(exp_pc, program_counter_out);
			repeat (4) @(posedge clk_sys_in);
		end
	endtask
	task automatic t_no_ovf;
		step(16'he57f, 2'h2);
		step(16'he57f, 2'h1);
		step(16'he580, 2'h0);
	endtask
	task automatic t_nonzero;
		step(16'he1fe, 2'h1);
		step(16'he1fe, 2'h2);
		step(16'he601, 2'h0);
		step(16'he100, 2'h3);
		step(16'h0000, 2'h0);
	endtask
	// enable low for four edges; phase and counter must be frozen when checked after three
	task automatic t_freeze;
		clk_en <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		cmp_phase(2'h0, phase_out);
		cmp_pc(exp_pc, program_counter_out);
		@(posedge clk_sys_in);
		clk_en <= 1'b1;
		step(16'he5fe, 2'h0);
	endtask
	task automatic stop_test(input bit hung);
		if (hung) miscompares++;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// reset for 8 cycles, then run the scenarios back to back
	initial
	begin
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_no_ovf();
		t_nonzero();
		t_freeze();
		stop_test(1'b0);
	end
endmodule
